// ### pkg/boost_ctrl_pkg.sv
// constants and types for the led fault and adaptive boost controller
//
// Notes on behaviour
// - any active sink below low threshold steps the boost target up
// - all active sinks above mid threshold step the boost target down
// - lowest active sink at low threshold holds the target
// - open or shorted strings are left out of the step decision
// - grounded sinks found at start-up are disabled and ignored everywhere
// - sink outputs follow the pwm input; host keeps 100 Hz to 20 kHz
// - input undervoltage shuts all down, enters recovery, fault low
// - undervoltage armed in soft-start, boost-start and normal only
// - input overvoltage shuts all down, enters recovery, fault low
// - input overvoltage armed in soft-start, boost-start and normal only
// - recovery lasts 100 ms then start-up is retried
// - feedback overvoltage shuts all down, enters recovery, fault low
// - feedback overvoltage armed only in normal
// - switch-node overvoltage shuts down, enters recovery; armed in three states
// - each sink gives low, mid and high comparator results
// - open string: target at maximum and used sink still low; drop it
// - short: sink above high while another in window; drop those high
// - string fault detection only in normal
// - string fault pulls fault low, stays normal, drops only that string
// - enable low 2 us to 50 us clears string faults, leds off meanwhile
// - enable low longer than the short pulse enters standby
// - light load skips switching cycles to avoid overshoot
// - enable low more than 50 us returns to standby
// - soft-start lasts 65 ms then boost-start
// - after 50 ms boost-start, grounded-sink check, then normal
// - entering normal with no fault releases fault output high
package boost_ctrl_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned NUM_SINKS = 4;
    localparam int unsigned TARGET_W = 8;
    localparam logic [7:0] TARGET_MAX = 8'hFF;
    localparam logic [7:0] TARGET_INIT = 8'hE0;
    localparam int unsigned SOFT_START_MS = 65;
    localparam int unsigned BOOST_START_MS = 50;
    localparam int unsigned RECOVERY_MS = 100;
    localparam int unsigned EN_CLEAR_MIN_NS = 2000;
    localparam int unsigned EN_STANDBY_NS = 50000;
    localparam int unsigned STEP_PERIOD_NS = 10000;
    localparam int unsigned SOFT_START_CYC = SOFT_START_MS * (CLK_HZ / 1000);
    localparam int unsigned BOOST_START_CYC = BOOST_START_MS * (CLK_HZ / 1000);
    localparam int unsigned RECOVERY_CYC = RECOVERY_MS * (CLK_HZ / 1000);
    localparam int unsigned EN_CLEAR_CYC = (EN_CLEAR_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned EN_STANDBY_CYC = EN_STANDBY_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam int unsigned STEP_CYC = STEP_PERIOD_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam logic [2:0] SKIP_LIMIT = 3'h3;

    typedef enum logic [4:0] {
        ST_STANDBY = 5'b00001,
        ST_SOFT_START = 5'b00010,
        ST_BOOST_START = 5'b00100,
        ST_NORMAL = 5'b01000,
        ST_RECOVERY = 5'b10000
    } state_e;

    function automatic logic armed_supply(input state_e s);
        armed_supply = (s == ST_SOFT_START) || (s == ST_BOOST_START) || (s == ST_NORMAL);
    endfunction : armed_supply
endpackage : boost_ctrl_pkg

// ### hw/sync_2ff.sv
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
    parameter int unsigned W = 1
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            meta_q <= '0;
            q_out <= '0;
        end
        else
        begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule : sync_2ff
`default_nettype wire

// ### hw/led_fault_adaptive_boost_ctrl.sv
// state machine, adaptive boost stepping and fault logic
`timescale 1ns/1ns
`default_nettype none
module led_fault_adaptive_boost_ctrl
    import boost_ctrl_pkg::*;
#(
    parameter int unsigned SOFT_START_CYCLES = SOFT_START_CYC,
    parameter int unsigned BOOST_START_CYCLES = BOOST_START_CYC,
    parameter int unsigned RECOVERY_CYCLES = RECOVERY_CYC
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic io_supply_enable_pin_in,
    input wire logic pwm_in,
    input wire logic [3:0] sink_below_low_in,
    input wire logic [3:0] sink_below_mid_in,
    input wire logic [3:0] sink_above_high_in,
    input wire logic input_undervoltage_in,
    input wire logic input_overvoltage_in,
    input wire logic feedback_overvoltage_in,
    input wire logic switch_node_overvoltage_in,
    input wire logic light_load_in,
    output logic [3:0] led_sink_output_out,
    output logic boost_enable_out,
    output logic boost_switch_enable_out,
    output logic power_switch_enable_out,
    output logic [7:0] boost_target_out,
    output logic fault_n_out,
    output logic fault_n_oe_out,
    output logic open_string_fault_out,
    output logic shorted_string_fault_out,
    output logic [4:0] state_out
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [17:0] raw_w;
    logic [17:0] syn_w;
    assign raw_w = {io_supply_enable_pin_in, pwm_in, sink_below_low_in, sink_below_mid_in,
                    sink_above_high_in, input_undervoltage_in, input_overvoltage_in,
                    feedback_overvoltage_in, switch_node_overvoltage_in};

    sync_2ff #(.W(18)) u_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .d_in(raw_w),
        .q_out(syn_w)
    );

    logic en_s, pwm_s, uv_s, ov_s, fbov_s, swov_s, ll_q;
    logic [3:0] low_s, mid_s, high_s;
    assign en_s = syn_w[17];
    assign pwm_s = syn_w[16];
    assign low_s = syn_w[15:12];
    assign mid_s = syn_w[11:8];
    assign high_s = syn_w[7:4];
    assign uv_s = syn_w[3];
    assign ov_s = syn_w[2];
    assign fbov_s = syn_w[1];
    assign swov_s = syn_w[0];

    // ----------------------------------------------------------------
    // state and timers
    // ----------------------------------------------------------------
    state_e state_q;
    logic [31:0] timer_q;
    logic [15:0] en_low_q;
    logic [3:0] grounded_q, dropped_q;
    logic was_recovery_q;
    logic supply_fault_w, standby_req_w, short_clear_w, ground_check_w;
    logic [3:0] used_w;

    assign used_w = ~grounded_q & ~dropped_q;
    assign supply_fault_w = (armed_supply(state_q) && (uv_s || ov_s || swov_s))
        || (state_q == ST_NORMAL && fbov_s);
    assign standby_req_w = !en_s && (en_low_q >= 16'(EN_STANDBY_CYC));
    assign short_clear_w = en_s && (en_low_q >= 16'(EN_CLEAR_CYC))
        && (en_low_q < 16'(EN_STANDBY_CYC));
    assign ground_check_w = (state_q == ST_BOOST_START)
        && (timer_q >= BOOST_START_CYCLES - 1);

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            en_low_q <= '0;
        else if (en_s)
            en_low_q <= '0;
        else if (en_low_q != 16'hFFFF)
            en_low_q <= en_low_q + 16'h0001;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_q <= ST_STANDBY;
            timer_q <= '0;
            was_recovery_q <= 1'b0;
        end
        else
        begin
            timer_q <= timer_q + 32'h1;
            case (state_q)
                ST_STANDBY:
                begin
                    timer_q <= '0;
                    if (en_s)
                        state_q <= ST_SOFT_START;
                end
                ST_SOFT_START, ST_BOOST_START, ST_NORMAL:
                begin
                    if (supply_fault_w)
                    begin
                        state_q <= ST_RECOVERY;
                        timer_q <= '0;
                        was_recovery_q <= 1'b1;
                    end
                    else if (standby_req_w)
                    begin
                        state_q <= ST_STANDBY;
                        timer_q <= '0;
                    end
                    else if (state_q == ST_SOFT_START && timer_q >= SOFT_START_CYCLES - 1)
                    begin
                        state_q <= ST_BOOST_START;
                        timer_q <= '0;
                    end
                    else if (ground_check_w)
                    begin
                        state_q <= ST_NORMAL;
                        timer_q <= '0;
                    end
                    else if (state_q == ST_NORMAL)
                        was_recovery_q <= 1'b0;
                end
                ST_RECOVERY:
                begin
                    if (timer_q >= RECOVERY_CYCLES - 1)
                    begin
                        timer_q <= '0;
                        state_q <= en_s ? ST_SOFT_START : ST_STANDBY;
                    end
                end
                default:
                begin
                    state_q <= ST_STANDBY;
                    timer_q <= '0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // grounded sinks and string faults
    // ----------------------------------------------------------------
    logic open_hit_w, short_hit_w, step_tick_w;
    assign open_hit_w = (state_q == ST_NORMAL) && (boost_target_out == TARGET_MAX)
        && |(low_s & used_w) && step_tick_w;
    assign short_hit_w = (state_q == ST_NORMAL) && |(high_s & used_w)
        && |(~low_s & mid_s & used_w);

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            grounded_q <= '0;
        else if (state_q == ST_STANDBY)
            grounded_q <= '0;
        else if (ground_check_w)
            grounded_q <= low_s;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            dropped_q <= '0;
            open_string_fault_out <= 1'b0;
            shorted_string_fault_out <= 1'b0;
        end
        else
        begin
            if (state_q != ST_NORMAL)
                dropped_q <= '0;
            else if (open_hit_w || short_hit_w)
                dropped_q <= dropped_q | (open_hit_w ? (low_s & used_w) : 4'h0)
                    | (short_hit_w ? (high_s & used_w) : 4'h0);
            // set wins over the clearing pulse
            if (open_hit_w)
                open_string_fault_out <= 1'b1;
            else if (short_clear_w || state_q != ST_NORMAL)
                open_string_fault_out <= 1'b0;
            if (short_hit_w)
                shorted_string_fault_out <= 1'b1;
            else if (short_clear_w || state_q != ST_NORMAL)
                shorted_string_fault_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // adaptive boost target
    // ----------------------------------------------------------------
    logic [15:0] step_cnt_q;
    logic any_low_w, any_at_w;
    assign step_tick_w = (step_cnt_q == 16'(STEP_CYC - 1));
    assign any_low_w = |(low_s & used_w);
    // lowest used sink inside the window just above the low threshold
    assign any_at_w = |(~low_s & mid_s & used_w);

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            step_cnt_q <= '0;
        else if (step_tick_w)
            step_cnt_q <= '0;
        else
            step_cnt_q <= step_cnt_q + 16'h0001;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            boost_target_out <= TARGET_INIT;
        else if (state_q != ST_NORMAL)
            boost_target_out <= TARGET_INIT;
        else if (step_tick_w && used_w != 4'h0)
        begin
            if (any_low_w)
            begin
                if (boost_target_out != TARGET_MAX)
                    boost_target_out <= boost_target_out + 8'h01;
            end
            else if (any_at_w)
                boost_target_out <= boost_target_out;
            else if (boost_target_out != 8'h00)
                boost_target_out <= boost_target_out - 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic [2:0] skip_q;
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            ll_q <= 1'b0;
        else
            ll_q <= light_load_in;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            skip_q <= '0;
            boost_switch_enable_out <= 1'b0;
        end
        else
        begin
            skip_q <= (skip_q == SKIP_LIMIT) ? 3'h0 : skip_q + 3'h1;
            boost_switch_enable_out <= boost_enable_out
                && !(ll_q && skip_q != 3'h0);
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            led_sink_output_out <= '0;
            boost_enable_out <= 1'b0;
            power_switch_enable_out <= 1'b0;
            fault_n_out <= 1'b0;
            fault_n_oe_out <= 1'b0;
            state_out <= ST_STANDBY;
        end
        else
        begin
            state_out <= state_q;
            boost_enable_out <= (state_q == ST_BOOST_START) || (state_q == ST_NORMAL);
            power_switch_enable_out <= armed_supply(state_q);
            led_sink_output_out <= (state_q == ST_NORMAL && pwm_s && en_s)
                ? used_w : 4'h0;
            // fault pin: open drain, pulled low while any fault shown
            fault_n_oe_out <= (state_q == ST_RECOVERY) || open_string_fault_out
                || shorted_string_fault_out || (was_recovery_q && state_q != ST_NORMAL
                && state_q != ST_STANDBY);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_fault_recovery: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (supply_fault_w && state_q != ST_RECOVERY) |=> state_q == ST_RECOVERY)
        else $error("supply fault did not enter recovery");
    chk_fbov_normal: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (fbov_s && !uv_s && !ov_s && !swov_s && state_q == ST_BOOST_START
         && !ground_check_w && !standby_req_w) |=> state_q != ST_RECOVERY)
        else $error("feedback overvoltage acted outside normal");
    chk_recovery_pin: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_q == ST_RECOVERY |=> fault_n_oe_out)
        else $error("fault pin not low in recovery");
    chk_leds_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_q != ST_NORMAL || !pwm_s) |=> led_sink_output_out == 4'h0)
        else $error("leds on without pwm or normal");
    chk_step_up: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_q == ST_NORMAL && step_tick_w && any_low_w && boost_target_out != TARGET_MAX
         && !supply_fault_w && !standby_req_w)
        |=> boost_target_out == $past(boost_target_out) + 8'h01)
        else $error("target did not step up");
    chk_hold_at: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_q == ST_NORMAL && step_tick_w && !any_low_w && any_at_w
         && !supply_fault_w && !standby_req_w)
        |=> $stable(boost_target_out))
        else $error("target moved while at threshold");
    chk_dropped_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_q == ST_NORMAL) |=> (led_sink_output_out & $past(dropped_q)) == 4'h0)
        else $error("dropped string still driven");
    chk_soft_len: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_q == ST_SOFT_START && timer_q < SOFT_START_CYCLES - 1 && !supply_fault_w
         && !standby_req_w) |=> state_q == ST_SOFT_START)
        else $error("soft-start left early");
    chk_no_fault_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_q == ST_STANDBY) |=> state_q != ST_RECOVERY)
        else $error("fault acted in standby");
endmodule : led_fault_adaptive_boost_ctrl
`default_nettype wire

// ### tb/led_string_model.sv
// led string model that drives the three sink comparators of each string
`timescale 1ns/1ns
`default_nettype none
module led_string_model #(
    parameter int LOW_LVL = 8,
    parameter int MID_LVL = 24,
    parameter int HIGH_LVL = 80
) (
    input wire logic clk_in,
    input wire logic [7:0] boost_target_in,
    input wire logic [3:0][7:0] need_in,
    input wire logic [3:0][1:0] mode_in,
    output logic [3:0] below_low_out,
    output logic [3:0] below_mid_out,
    output logic [3:0] above_high_out
);
    // ------------------------------------------------------------
    // cathode level from target minus string drop
    // ------------------------------------------------------------
    // modes: 0 lit, 1 open, 2 shorted, 3 grounded
    int v;
    always @(negedge clk_in)
    begin
        for (int i = 0; i < 4; i++)
        begin
            v = int'(boost_target_in) - int'(need_in[i]);
            if (mode_in[i] == 2'h1 || mode_in[i] == 2'h3)
                v = 0;
            if (mode_in[i] == 2'h2)
                v = 255;
            below_low_out[i] <= (v < LOW_LVL);
            below_mid_out[i] <= (v < MID_LVL);
            above_high_out[i] <= (v > HIGH_LVL);
        end
    end
endmodule : led_string_model
`default_nettype wire

// ### tb/tb_led_fault_adaptive_boost_ctrl.sv
// self-checking bench for the led fault and adaptive boost controller
`timescale 1ns/1ns
`default_nettype none
module tb_led_fault_adaptive_boost_ctrl
    import boost_ctrl_pkg::*;
;
    localparam int SS = 50;
    localparam int BS = 40;
    localparam int RC = 60;
    logic clk_in = 1'b0;
    logic reset_n_in;
    logic en, pwm, light;
    logic [3:0] sup_f;
    logic [3:0] blow, bmid, bhigh, sinks;
    logic [3:0][7:0] need;
    logic [3:0][1:0] mode;
    logic boost_en, sw_en, pwr_en, flt_n, flt_oe, open_f, short_f;
    logic [7:0] target;
    logic [4:0] state_out;
    int err_total = 0;
    int checks = 0;
    int n;
    always #5 clk_in = ~clk_in;

    led_fault_adaptive_boost_ctrl #(.SOFT_START_CYCLES(SS), .BOOST_START_CYCLES(BS),
        .RECOVERY_CYCLES(RC)) u_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .io_supply_enable_pin_in(en),
        .pwm_in(pwm), .sink_below_low_in(blow), .sink_below_mid_in(bmid),
        .sink_above_high_in(bhigh), .input_undervoltage_in(sup_f[0]),
        .input_overvoltage_in(sup_f[1]), .feedback_overvoltage_in(sup_f[2]),
        .switch_node_overvoltage_in(sup_f[3]), .light_load_in(light),
        .led_sink_output_out(sinks), .boost_enable_out(boost_en),
        .boost_switch_enable_out(sw_en), .power_switch_enable_out(pwr_en),
        .boost_target_out(target), .fault_n_out(flt_n), .fault_n_oe_out(flt_oe),
        .open_string_fault_out(open_f), .shorted_string_fault_out(short_f),
        .state_out(state_out));

    led_string_model u_strings (
        .clk_in(clk_in), .boost_target_in(target), .need_in(need), .mode_in(mode),
        .below_low_out(blow), .below_mid_out(bmid), .above_high_out(bhigh));

    // ------------------------------------------------------------
    // compare, wait and closing tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cycles(input int k);
        repeat (k) @(negedge clk_in);
    endtask : cycles

    task automatic wait_st(input state_e s, input int lim, output int k);
        k = 0;
        while (state_out !== s && k < lim)
        begin
            @(negedge clk_in);
            k++;
        end
    endtask : wait_st

    task automatic wrap_up();
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (100000) @(posedge clk_in);
        err_total++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        reset_n_in = 1'b0;
        en = 1'b0;
        pwm = 1'b0;
        light = 1'b0;
        sup_f = 4'h0;
        need = {4{8'hD0}};
        mode = {2'h3, 2'h0, 2'h0, 2'h0};
        cycles(20);
        reset_n_in = 1'b1;
        cycles(2);
        chk("reset state", state_out, ST_STANDBY);
        chk("reset target", target, TARGET_INIT);
        sup_f = 4'hF;
        cycles(10);
        chk("standby ignores", state_out, ST_STANDBY);
        chk("standby fault", flt_oe, 1'b0);
        sup_f = 4'h0;
        pwm = 1'b1;
        en = 1'b1;
        wait_st(ST_SOFT_START, 10, n);
        cycles(2);
        chk("soft power", pwr_en, 1'b1);
        chk("soft boost", boost_en, 1'b0);
        wait_st(ST_BOOST_START, SS + 5, n);
        chk("soft length", (n >= SS - 4 && n <= SS + 2), 1'b1);
        sup_f = 4'h4;
        cycles(6);
        chk("fb ov unarmed", state_out, ST_BOOST_START);
        sup_f = 4'h0;
        wait_st(ST_NORMAL, BS + 5, n);
        chk("boost length", (n >= BS - 10 && n <= BS + 2), 1'b1);
        cycles(10);
        chk("sinks on", sinks, 4'h7);
        chk("hold in window", target, TARGET_INIT);
        pwm = 1'b0;
        cycles(5);
        chk("sinks off", sinks, 4'h0);
        pwm = 1'b1;
        need = {4{8'hF0}};
        cycles(3000);
        chk("step up", (target > TARGET_INIT), 1'b1);
        cycles(27000);
        chk("settled", (target >= 8'hF4 && target <= 8'hFE), 1'b1);
        mode[0] = 2'h1;
        n = 0;
        while (open_f !== 1'b1 && n < 12000)
        begin
            @(negedge clk_in);
            n++;
        end
        chk("open flag", open_f, 1'b1);
        chk("open at max", target, TARGET_MAX);
        cycles(5);
        chk("open dropped", sinks, 4'h6);
        chk("open pin", flt_oe, 1'b1);
        chk("open stays", state_out, ST_NORMAL);
        need[1] = 8'hD0;
        need[2] = 8'hD0;
        cycles(3000);
        chk("step down", (target < TARGET_MAX), 1'b1);
        need[1] = target - 8'h10;
        mode[2] = 2'h2;
        n = 0;
        while (short_f !== 1'b1 && n < 3000)
        begin
            @(negedge clk_in);
            n++;
        end
        cycles(5);
        chk("short flag", short_f, 1'b1);
        chk("short dropped", sinks, 4'h2);
        chk("short stays", state_out, ST_NORMAL);
        en = 1'b0;
        cycles(500);
        chk("clear leds off", sinks, 4'h0);
        chk("clear state", state_out, ST_NORMAL);
        en = 1'b1;
        cycles(10);
        chk("clear open", open_f, 1'b0);
        chk("clear short", short_f, 1'b0);
        chk("clear pin", flt_oe, 1'b0);
        light = 1'b1;
        cycles(8);
        n = 0;
        repeat (40)
        begin
            @(negedge clk_in);
            n += int'(sw_en);
        end
        chk("skip count", n, 10);
        light = 1'b0;
        mode = {2'h3, 2'h0, 2'h0, 2'h0};
        need = {4{8'hD0}};
        for (int k = 0; k < 4; k++)
        begin
            sup_f = 4'h1 << k;
            cycles(5);
            sup_f = 4'h0;
            chk("recovery", state_out, ST_RECOVERY);
            chk("rec pin", flt_oe, 1'b1);
            chk("rec pin data", flt_n, 1'b0);
            chk("rec off", {boost_en, pwr_en, sinks}, 6'h00);
            wait_st(ST_SOFT_START, RC + 10, n);
            chk("rec length", (n >= RC - 8 && n <= RC + 2), 1'b1);
            wait_st(ST_NORMAL, SS + BS + 20, n);
            cycles(3);
            chk("restart normal", state_out, ST_NORMAL);
            chk("pin released", flt_oe, 1'b0);
        end
        en = 1'b0;
        cycles(EN_STANDBY_CYC + 20);
        chk("long low", state_out, ST_STANDBY);
        wrap_up();
    end
endmodule : tb_led_fault_adaptive_boost_ctrl
`default_nettype wire
